// [verilog/serial_link_tx_config.sv]
// Contract
// - test selector picks normal, clock, encoded, prbs15
// - long test pattern when enable set
// - sync code BCBC or BC50 during request
// - reverse sample bit order when set
// - insert lane markers when enabled
// - insert frame markers when enabled
// - skip alignment sequence when bit set
// - nine frames per multiframe unless overridden
// - two octets per frame unless overridden
// - scramble data when scrambler bit set
// - octet field selects 20x or 40x
// - five bit frames field resets to eight
// - subclass field latched at sync and shown on subclassActive only
// - software resync acts only when selected
// - resync source is pins or software
// - drive code maps to output current
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "sltc_defs.svh"
module serial_link_tx_config
  import sltc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic resync_pin_pos,
  input wire logic resync_pin_neg,
  input wire logic [15:0] sampleIn,
  output logic [15:0] laneData,
  output logic [1:0] laneCtrlK,
  output logic [5:0] driveMilliAmp,
  output logic [2:0] subclassActive
);
  sltc_bus_t bus;
  sltc_cfg_t cfg;
  logic swResync;
  logic resyncSrc;
  logic [2:0] driveCode;
  logic pinPos;
  logic pinNeg;
  logic [7:0] statusByte;

  typedef struct packed {
    sltc_state_t state;
    sltc_cfg_t act;
    logic [7:0] octCnt;
    logic [4:0] frmCnt;
    logic [2:0] mfCnt;
    logic [14:0] prbs;
    logic [14:0] scr;
    logic [7:0] lastOct;
    logic [15:0] data;
    logic [1:0] ctrlK;
    logic [5:0] mA;
    logic [2:0] sub;
    logic syncReq;
  } sltc_top_t;
  sltc_top_t st_ff;
  sltc_top_t nxt_st;

  assign bus = '{addr: regAddr, wdata: regWrData, wr: regWr, rd: regRd};
  assign statusByte = {st_ff.state, 3'h0, st_ff.syncReq};

  sltc_regs u_regs (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .bus(bus),
    .statusIn(statusByte),
    .rdData(regRdData),
    .cfg(cfg),
    .swResync(swResync),
    .resyncSrc(resyncSrc),
    .driveCode(driveCode)
  );

  // both legs synchronised; pair counts as a request only with pos low and neg high
  sltc_pin_sync u_pos (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pinIn(resync_pin_pos),
    .level(pinPos)
  );
  sltc_pin_sync u_neg (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pinIn(resync_pin_neg),
    .level(pinNeg)
  );

  // request active low on the pin pair
  logic pinReq;
  logic reqNow;
  assign pinReq = !pinPos && pinNeg;
  assign reqNow = resyncSrc ? swResync : pinReq;

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  function automatic logic [5:0] milliAmp(input logic [2:0] c);
    logic [5:0] m;
    m = 6'h00;
    case (c)
      3'h0: m = 6'h10;
      3'h1: m = 6'h0C;
      3'h2: m = 6'h08;
      3'h3: m = 6'h04;
      3'h4: m = 6'h20;
      3'h5: m = 6'h1C;
      3'h6: m = 6'h18;
      default: m = 6'h14;
    endcase
    return m;
  endfunction

  logic [7:0] effOct;
  logic [4:0] effK;
  logic lastOfFrame;
  logic lastOfMf;
  logic [15:0] payload;
  logic [15:0] scrWord;
  logic [14:0] scrNext;
  logic [14:0] prbsNext;

  always_comb begin
    nxt_st = st_ff;
    // frame geometry from latched settings only
    effOct = st_ff.act.fOverride ? st_ff.act.octets : `SLTC_OCT_20X;
    effK = st_ff.act.kOverride ? st_ff.act.frames : `SLTC_K_DEF_NOOVR;
    // octets counted two per word; 40x code gives four per frame
    lastOfFrame = (effOct == `SLTC_OCT_40X) ? st_ff.octCnt[0] : 1'b1;
    lastOfMf = lastOfFrame && (st_ff.frmCnt >= effK - 5'h01);
    prbsNext = {st_ff.prbs[13:0], st_ff.prbs[14] ^ st_ff.prbs[13]};
    case (st_ff.act.testSel)
      2'h1: payload = 16'hAAAA;
      2'h2: payload = {st_ff.octCnt, 3'h0, st_ff.frmCnt};
      2'h3: payload = {st_ff.prbs, st_ff.prbs[14]};
      default: payload = sampleIn;
    endcase
    if (st_ff.act.longPat) begin
      payload = {st_ff.frmCnt, 3'h0, st_ff.octCnt};
    end
    if (st_ff.act.bitReverse) begin
      payload = rev16(payload);
    end
    // self-synchronous scrambler, 1 + x^14 + x^15, per word
    scrNext = st_ff.scr;
    for (int i = 15; i >= 0; i--) begin
      scrWord[i] = payload[i] ^ scrNext[13] ^ scrNext[14];
      scrNext = {scrNext[13:0], scrWord[i]};
    end
    nxt_st.syncReq = reqNow;
    nxt_st.mA = milliAmp(driveCode);
    nxt_st.sub = st_ff.act.subclass;
    nxt_st.ctrlK = 2'h0;
    case (st_ff.state)
      SLTC_SYNC: begin
        nxt_st.act = cfg;
        nxt_st.data = cfg.syncCodeSel ? `SLTC_SYNC_ALT : `SLTC_SYNC_K;
        nxt_st.ctrlK = cfg.syncCodeSel ? 2'h2 : 2'h3;
        nxt_st.octCnt = 8'h00;
        nxt_st.frmCnt = 5'h00;
        nxt_st.mfCnt = 3'h0;
        nxt_st.scr = `SLTC_PRBS_SEED;
        if (!reqNow) begin
          nxt_st.state = cfg.alignmentSkip ? SLTC_DATA : SLTC_ILAS;
        end
      end
      SLTC_ILAS: begin
        nxt_st.data = {`SLTC_K_ILAS, 8'h00};
        nxt_st.ctrlK = 2'h2;
        if (lastOfMf) begin
          nxt_st.mfCnt = st_ff.mfCnt + 3'h1;
          if (st_ff.mfCnt == `SLTC_ILAS_MF - 3'h1) begin
            nxt_st.state = SLTC_DATA;
          end
        end
      end
      SLTC_DATA: begin
        nxt_st.data = st_ff.act.scramblerOn ? scrWord : payload;
        if (st_ff.act.scramblerOn) begin
          nxt_st.scr = scrNext;
        end
        nxt_st.prbs = prbsNext;
        // markers replace last octet of a frame or multiframe
        if (lastOfMf && st_ff.act.laneMarker) begin
          nxt_st.data[7:0] = `SLTC_K_LANE;
          nxt_st.ctrlK = 2'h1;
        end else if (lastOfFrame && st_ff.act.frameMarker) begin
          nxt_st.data[7:0] = `SLTC_K_FRAME;
          nxt_st.ctrlK = 2'h1;
        end
      end
      default: nxt_st.state = SLTC_SYNC;
    endcase
    if (st_ff.state != SLTC_SYNC) begin
      if (lastOfFrame) begin
        nxt_st.octCnt = 8'h00;
        nxt_st.frmCnt = lastOfMf ? 5'h00 : st_ff.frmCnt + 5'h01;
      end else begin
        nxt_st.octCnt = st_ff.octCnt + 8'h01;
      end
      if (reqNow) begin
        nxt_st.state = SLTC_SYNC;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '{state: SLTC_SYNC, act: '0, octCnt: 8'h00, frmCnt: 5'h00, mfCnt: 3'h0,
        prbs: `SLTC_PRBS_SEED, scr: `SLTC_PRBS_SEED, lastOct: 8'h00, data: 16'h0000,
        ctrlK: 2'h0, mA: 6'h10, sub: 3'h0, syncReq: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign laneData = st_ff.data;
  assign laneCtrlK = st_ff.ctrlK;
  assign driveMilliAmp = st_ff.mA;
  assign subclassActive = st_ff.sub;

  chk_sync_code: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_ff.state == SLTC_SYNC && !cfg.syncCodeSel) |=> (laneCtrlK == 2'h3))
    else $error("sync code check");
  chk_sync_word: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_ff.state == SLTC_SYNC && !cfg.syncCodeSel) |=> (laneData == 16'hBCBC))
    else $error("sync word wrong");
  chk_sync_alt: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_ff.state == SLTC_SYNC && cfg.syncCodeSel) |=> (laneData == 16'hBC50))
    else $error("alternate sync word wrong");
  chk_skip_align: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_ff.state == SLTC_SYNC && !reqNow && cfg.alignmentSkip) |=> (st_ff.state == SLTC_DATA))
    else $error("alignment not skipped");
  chk_do_align: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_ff.state == SLTC_SYNC && !reqNow && !cfg.alignmentSkip) |=> (st_ff.state == SLTC_ILAS))
    else $error("alignment missing");
  chk_sw_resync: assert property (@(posedge ref_clk) disable iff (!nrst)
    (resyncSrc && !swResync) |=> !st_ff.syncReq)
    else $error("software resync leaked");
  chk_clock_pat: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_ff.state == SLTC_DATA && !reqNow && st_ff.act.testSel == 2'h1 && !st_ff.act.longPat
     && !st_ff.act.bitReverse && !st_ff.act.scramblerOn && !st_ff.act.laneMarker
     && !st_ff.act.frameMarker) |=> (laneData == 16'hAAAA))
    else $error("clock pattern wrong");
  chk_drive_map: assert property (@(posedge ref_clk) disable iff (!nrst)
    (driveCode == 3'h4) |=> (driveMilliAmp == 6'h20))
    else $error("drive current wrong");
  chk_cfg_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_ff.state != SLTC_SYNC) |=> $stable(st_ff.act))
    else $error("settings changed mid link");
endmodule
`default_nettype wire

// [verilog/sltc_defs.svh]
`ifndef SLTC_DEFS_SVH
`define SLTC_DEFS_SVH
`define SLTC_OFF_TEST 8'h2A
`define SLTC_OFF_OVR 8'h2B
`define SLTC_OFF_SCR 8'h2F
`define SLTC_OFF_OCT 8'h30
`define SLTC_OFF_MFL 8'h31
`define SLTC_OFF_SUB 8'h34
`define SLTC_OFF_RSD 8'h3A
`define SLTC_OFF_STAT 8'h3E
`define SLTC_RST_TEST 8'h00
`define SLTC_RST_OVR 8'h00
`define SLTC_RST_SCR 8'h00
`define SLTC_RST_OCT 8'h00
`define SLTC_RST_MFL 8'h08
`define SLTC_RST_SUB 8'h20
`define SLTC_RST_RSD 8'h00
`define SLTC_MSK_OVR 8'h03
`define SLTC_MSK_SCR 8'h80
`define SLTC_MSK_MFL 8'h1F
`define SLTC_MSK_SUB 8'hE0
`define SLTC_MSK_RSD 8'hCE
`define SLTC_SYNC_K 16'hBCBC
`define SLTC_SYNC_ALT 16'hBC50
`define SLTC_K_LANE 8'h7C
`define SLTC_K_FRAME 8'hFC
`define SLTC_K_ILAS 8'h1C
`define SLTC_K_DEF 5'h08
`define SLTC_K_DEF_NOOVR 5'h09
`define SLTC_OCT_20X 8'h00
`define SLTC_OCT_40X 8'h03
`define SLTC_ILAS_MF 3'h4
`define SLTC_PRBS_SEED 15'h7FFF
`endif

// [verilog/sltc_pkg.sv]
package sltc_pkg;
  typedef struct packed {
    logic [1:0] testSel;
    logic longPat;
    logic syncCodeSel;
    logic bitReverse;
    logic laneMarker;
    logic frameMarker;
    logic alignmentSkip;
    logic kOverride;
    logic fOverride;
    logic scramblerOn;
    logic [7:0] octets;
    logic [4:0] frames;
    logic [2:0] subclass;
  } sltc_cfg_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sltc_bus_t;
  typedef enum logic [3:0] {
    SLTC_SYNC = 4'h1,
    SLTC_ILAS = 4'h2,
    SLTC_DATA = 4'h4,
    SLTC_IDLE = 4'h8
  } sltc_state_t;
endpackage

// [verilog/sltc_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module sltc_pin_sync
  import sltc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pinIn,
  output logic level
);
  typedef struct packed {
    logic [2:0] sh;
    logic lvl;
  } sltc_sync_t;
  sltc_sync_t st_ff;
  sltc_sync_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sh = {st_ff.sh[1:0], pinIn};
    // change counts only once stages two and three agree
    if (st_ff.sh[2] == st_ff.sh[1]) begin
      nxt_st.lvl = st_ff.sh[2];
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign level = st_ff.lvl;
endmodule
`default_nettype wire

// [verilog/sltc_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sltc_defs.svh"
module sltc_regs
  import sltc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire sltc_bus_t bus,
  input wire logic [7:0] statusIn,
  output logic [7:0] rdData,
  output sltc_cfg_t cfg,
  output logic swResync,
  output logic resyncSrc,
  output logic [2:0] driveCode
);
  typedef struct packed {
    logic [7:0] test;
    logic [7:0] ovr;
    logic [7:0] scr;
    logic [7:0] oct;
    logic [7:0] mfl;
    logic [7:0] sub;
    logic [7:0] rsd;
    logic [7:0] rd;
  } sltc_rf_t;
  sltc_rf_t st_ff;
  sltc_rf_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    // reserved bits are masked so they always read zero
    if (bus.wr) begin
      case (bus.addr)
        `SLTC_OFF_TEST: nxt_st.test = bus.wdata;
        `SLTC_OFF_OVR: nxt_st.ovr = bus.wdata & `SLTC_MSK_OVR;
        `SLTC_OFF_SCR: nxt_st.scr = bus.wdata & `SLTC_MSK_SCR;
        `SLTC_OFF_OCT: nxt_st.oct = bus.wdata;
        `SLTC_OFF_MFL: nxt_st.mfl = bus.wdata & `SLTC_MSK_MFL;
        `SLTC_OFF_SUB: nxt_st.sub = bus.wdata & `SLTC_MSK_SUB;
        `SLTC_OFF_RSD: nxt_st.rsd = bus.wdata & `SLTC_MSK_RSD;
        default: nxt_st.rd = st_ff.rd;
      endcase
    end
    nxt_st.rd = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `SLTC_OFF_TEST: nxt_st.rd = st_ff.test;
        `SLTC_OFF_OVR: nxt_st.rd = st_ff.ovr;
        `SLTC_OFF_SCR: nxt_st.rd = st_ff.scr;
        `SLTC_OFF_OCT: nxt_st.rd = st_ff.oct;
        `SLTC_OFF_MFL: nxt_st.rd = st_ff.mfl;
        `SLTC_OFF_SUB: nxt_st.rd = st_ff.sub;
        `SLTC_OFF_RSD: nxt_st.rd = st_ff.rsd;
        `SLTC_OFF_STAT: nxt_st.rd = statusIn;
        default: nxt_st.rd = 8'h00;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= {`SLTC_RST_TEST, `SLTC_RST_OVR, `SLTC_RST_SCR, `SLTC_RST_OCT,
        `SLTC_RST_MFL, `SLTC_RST_SUB, `SLTC_RST_RSD, 8'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign rdData = st_ff.rd;
  assign cfg = '{testSel: st_ff.test[7:6], longPat: st_ff.test[5],
    syncCodeSel: st_ff.test[4], bitReverse: st_ff.test[3], laneMarker: st_ff.test[2],
    frameMarker: st_ff.test[1], alignmentSkip: st_ff.test[0], kOverride: st_ff.ovr[1],
    fOverride: st_ff.ovr[0], scramblerOn: st_ff.scr[7], octets: st_ff.oct,
    frames: st_ff.mfl[4:0], subclass: st_ff.sub[7:5]};
  assign swResync = st_ff.rsd[7];
  assign resyncSrc = st_ff.rsd[6];
  assign driveCode = st_ff.rsd[3:1];
endmodule
`default_nettype wire

// [sim/sltc_rx_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sltc_rx_model
  import sltc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wantSync,
  input wire logic [15:0] laneData,
  input wire logic [1:0] laneCtrlK,
  output logic resync_pin_pos,
  output logic resync_pin_neg,
  output logic [7:0] syncWords
);
  // request drawn as pos low, neg high; idle is the opposite pair
  assign resync_pin_pos = ~wantSync;
  assign resync_pin_neg = wantSync;
  // counts sync words seen, kept so a stuck code shows up in waves
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      syncWords <= 8'h00;
    end else if (laneData[15:8] == 8'hBC && laneCtrlK[1]) begin
      syncWords <= syncWords + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sltc_defs.svh"
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin nMismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module testbench
  import sltc_pkg::*;
;
  logic ref_clk, nrst, regWr, regRd, rxWant, pinPos, pinNeg;
  logic [7:0] regAddr, regWrData, regRdData, d;
  logic [15:0] sampleIn, laneData;
  logic [1:0] laneCtrlK;
  logic [5:0] driveMilliAmp;
  logic [2:0] subclassActive;
  int nMismatch = 0;
  int totalChecks = 0;
  serial_link_tx_config dut (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .resync_pin_pos(pinPos), .resync_pin_neg(pinNeg), .sampleIn(sampleIn),
    .laneData(laneData), .laneCtrlK(laneCtrlK), .driveMilliAmp(driveMilliAmp),
    .subclassActive(subclassActive));
  sltc_rx_model rx (.ref_clk(ref_clk), .nrst(nrst), .wantSync(rxWant), .laneData(laneData),
    .laneCtrlK(laneCtrlK), .resync_pin_pos(pinPos), .resync_pin_neg(pinNeg), .syncWords());
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  // full request and release through the pins; settings latch here
  task automatic syncCycle(input logic [15:0] code, input logic [1:0] k);
    rxWant <= 1'b1;
    repeat (12) @(posedge ref_clk);
    #1;
    `CHK(laneData, code)
    `CHK(laneCtrlK, k)
    @(posedge ref_clk);
    rxWant <= 1'b0;
    repeat (60) @(posedge ref_clk);
    #1;
  endtask
  task automatic tRegs;
    logic [7:0] offs [8];
    logic [7:0] rsts [8];
    logic [7:0] msks [8];
    offs = '{`SLTC_OFF_TEST, `SLTC_OFF_OVR, `SLTC_OFF_SCR, `SLTC_OFF_OCT, `SLTC_OFF_MFL,
      `SLTC_OFF_SUB, `SLTC_OFF_RSD, 8'h00};
    rsts = '{`SLTC_RST_TEST, `SLTC_RST_OVR, `SLTC_RST_SCR, `SLTC_RST_OCT, `SLTC_RST_MFL,
      `SLTC_RST_SUB, `SLTC_RST_RSD, 8'h00};
    msks = '{8'hFF, `SLTC_MSK_OVR, `SLTC_MSK_SCR, 8'hFF, `SLTC_MSK_MFL, `SLTC_MSK_SUB,
      `SLTC_MSK_RSD, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd(offs[i]);
      `CHK(d, rsts[i])
    end
    // every defined bit set, reserved ones left at zero; frames stay at or above default
    for (int i = 0; i < 8; i++) begin
      wr(offs[i], msks[i]);
      rd(offs[i]);
      `CHK(d, msks[i])
      wr(offs[i], rsts[i]);
    end
  endtask
  task automatic tDrive;
    logic [5:0] amps [8];
    amps = '{6'h10, 6'h0C, 6'h08, 6'h04, 6'h20, 6'h1C, 6'h18, 6'h14};
    for (int i = 0; i < 8; i++) begin
      wr(`SLTC_OFF_RSD, {4'h0, i[2:0], 1'b0});
      repeat (3) @(posedge ref_clk);
      #1 `CHK(driveMilliAmp, amps[i])
    end
    wr(`SLTC_OFF_RSD, 8'h00);
  endtask
  task automatic tSync;
    syncCycle(`SLTC_SYNC_K, 2'h3);
    wr(`SLTC_OFF_TEST, 8'h10);
    syncCycle(`SLTC_SYNC_ALT, 2'h2);
    wr(`SLTC_OFF_RSD, 8'h80);
    repeat (6) @(posedge ref_clk);
    rd(`SLTC_OFF_STAT);
    `CHK(d[0], 1'b0)
    wr(`SLTC_OFF_RSD, 8'hC0);
    repeat (6) @(posedge ref_clk);
    rd(`SLTC_OFF_STAT);
    `CHK(d[0], 1'b1)
    `CHK(laneData, `SLTC_SYNC_ALT)
    wr(`SLTC_OFF_RSD, 8'h40);
    rd(`SLTC_OFF_STAT);
    `CHK(d[7:4], 4'h2)
    wr(`SLTC_OFF_TEST, 8'h01);
    wr(`SLTC_OFF_RSD, 8'hC0);
    repeat (4) @(posedge ref_clk);
    wr(`SLTC_OFF_RSD, 8'h40);
    rd(`SLTC_OFF_STAT);
    `CHK(d[7:4], 4'h4)
    wr(`SLTC_OFF_RSD, 8'h00);
  endtask
  task automatic tSubclass;
    for (int i = 0; i < 3; i++) begin
      wr(`SLTC_OFF_SUB, {i[2:0], 5'h00});
      syncCycle(`SLTC_SYNC_K, 2'h3);
      `CHK(subclassActive, i[2:0])
    end
  endtask
  task automatic tData;
    logic [15:0] revExp;
    wr(`SLTC_OFF_TEST, 8'h41);
    syncCycle(`SLTC_SYNC_K, 2'h3);
    `CHK(laneData, 16'hAAAA)
    // not latched until the next request, so the stream must not change
    wr(`SLTC_OFF_TEST, 8'h01);
    #1 `CHK(laneData, 16'hAAAA)
    syncCycle(`SLTC_SYNC_K, 2'h3);
    `CHK(laneData, sampleIn)
    wr(`SLTC_OFF_TEST, 8'h09);
    syncCycle(`SLTC_SYNC_K, 2'h3);
    revExp = {<<{sampleIn}};
    `CHK(laneData, revExp)
    wr(`SLTC_OFF_TEST, 8'h01);
    wr(`SLTC_OFF_SCR, 8'h80);
    syncCycle(`SLTC_SYNC_K, 2'h3);
    `CHK(laneData !== sampleIn, 1'b1)
    wr(`SLTC_OFF_SCR, 8'h00);
  endtask
  task automatic tMarkers;
    int hits;
    for (int m = 0; m < 2; m++) begin
      hits = 0;
      wr(`SLTC_OFF_TEST, m ? 8'h05 : 8'h03);
      syncCycle(`SLTC_SYNC_K, 2'h3);
      repeat (40) begin
        @(posedge ref_clk);
        #1 if (laneCtrlK[0] && laneData[7:0] == (m ? `SLTC_K_LANE : `SLTC_K_FRAME)) hits++;
      end
      `CHK(hits > 0, 1'b1)
    end
  endtask
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    nMismatch++;
    printVerdict();
  end
  initial begin
    nrst = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    rxWant = 1'b0;
    sampleIn = 16'h1234;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    tRegs();
    tDrive();
    tSync();
    tSubclass();
    tData();
    tMarkers();
    printVerdict();
  end
endmodule
`default_nettype wire
